// ---- hdl/rts_pkg.sv ----
// Constants, carrier types and state codes shared by the section trail source
package rts_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS   = 100;   // System clock period
  localparam int LINK_PERIOD_NS  = 800;   // Byte period of the adapted input
  localparam int FRAME_PERIOD_US = 125;   // Nominal frame period
  localparam int OUT_HALF_CYC    = (LINK_PERIOD_NS / CLK_PERIOD_NS) / 2;
  localparam logic [3:0] OUT_HALF_LAST = 4'(OUT_HALF_CYC - 1);
  localparam logic [3:0] OUT_CNT_RST   = 4'h0;

  // Frame geometry, rows and columns counted from one
  localparam logic [3:0]  ROW_FIRST     = 4'h1;
  localparam logic [3:0]  ROW_SECOND    = 4'h2;
  localparam logic [3:0]  ROW_LAST      = 4'h9;
  localparam logic [12:0] COL_FIRST     = 13'h0001;
  localparam logic [12:0] COL_LAST      = 13'h10e0;  // 4320 columns
  localparam logic [12:0] A1_LAST_COL   = 13'h0030;  // End of first alignment run
  localparam logic [12:0] A2_LAST_COL   = 13'h0060;  // End of second alignment run
  localparam logic [12:0] TRACE_COL     = 13'h0061;  // Section trace byte column
  localparam logic [12:0] PARITY_COL    = 13'h0001;  // Parity byte column, row two
  localparam logic [12:0] SOH_LAST_COL  = 13'h0090;  // Last unscrambled row-one column
  localparam logic [12:0] SCR_START_COL = 13'h0091;  // Scrambler reset column

  // Byte values
  localparam logic [7:0] FIRST_ALIGN_VALUE  = 8'hf6;
  localparam logic [7:0] SECOND_ALIGN_VALUE = 8'h28;
  localparam logic [7:0] BYTE_RST           = 8'h00;
  localparam logic [6:0] SCR_SEED           = 7'h7f;  // All stages set
  localparam logic [7:0] SCR_FIRST_KEY      = 8'hfe;  // Key byte right after seeding

  // Buffer shape
  localparam int FIFO_DEPTH = 16;

  // One byte of the section stream with its frame marker
  typedef struct packed {
    logic       frame_start;
    logic [7:0] data;
  } rts_byte_t;
  localparam int WORD_W = $bits(rts_byte_t);

  // Output pacing states
  typedef enum logic [2:0] {
    OUT_IDLE = 3'b001,
    OUT_LOW  = 3'b010,
    OUT_HIGH = 3'b100
  } rts_out_state_t;
endpackage

// ---- hdl/rts_fifo.sv ----
// Byte FIFO with registered head word, valid/ready on both sides
`timescale 1ns/100ps
module rts_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage behind the head word
  logic [PW-1:0]    wr_reg, wr_next;
  logic [PW-1:0]    rd_reg, rd_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             hv_reg, hv_next;      // Head word valid
  logic [WIDTH-1:0] head_reg, head_next;  // Head word, read data register
  logic             push;                 // Accepted write
  logic             bypass;               // Write goes straight to head
  logic             refill;               // Head reloads from storage

  assign in_ready  = (cnt_reg != FULL_CNT);
  assign out_valid = hv_reg;
  assign out_data  = head_reg;

  // Next pointers, count and head
  always_comb begin
    push      = in_valid && in_ready;
    refill    = (!hv_reg || out_ready) && (cnt_reg != '0);
    bypass    = (!hv_reg || out_ready) && (cnt_reg == '0) && push;
    wr_next   = wr_reg;
    rd_next   = rd_reg;
    cnt_next  = cnt_reg;
    hv_next   = hv_reg;
    head_next = head_reg;
    if (!hv_reg || out_ready) begin
      // Head free or leaving
      if (refill) begin
        head_next = mem[rd_reg];
        rd_next   = rd_reg + 1'b1;
        hv_next   = 1'b1;
      end else if (bypass) begin
        head_next = in_data;
        hv_next   = 1'b1;
      end else begin
        hv_next = 1'b0;
      end
    end
    if (push && !bypass) begin
      wr_next = wr_reg + 1'b1;
    end
    cnt_next = cnt_reg + CW'(push && !bypass) - CW'(refill);
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      hv_reg   <= 1'b0;
      head_reg <= '0;
    end else if (en) begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      cnt_reg  <= cnt_next;
      hv_reg   <= hv_next;
      head_reg <= head_next;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (en && push && !bypass) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule // rts_fifo

// ---- hdl/rts_trail_source.sv ----
// Section trail source: alignment, trace, parity, scrambling and byte output
`timescale 1ns/100ps
module rts_trail_source (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       en,
  input  wire logic [7:0] adapted_in_data,
  input  wire logic       adapted_in_clock,
  input  wire logic       adapted_in_frame_start,
  input  wire logic [7:0] transmitted_trace_id,
  output logic [7:0]      section_out_data,
  output logic            section_out_clock,
  output logic            section_out_frame_start,
  output logic            byte_dropped
);
  // Input synchronisers, two stages each
  logic [7:0] din_s1_reg, din_s2_reg;      // Data
  logic       ck_s1_reg, ck_s2_reg;        // Link clock
  logic       ck_s3_reg;                   // Link clock edge history
  logic       fs_s1_reg, fs_s2_reg;        // Frame start
  logic [7:0] ti_s1_reg, ti_s2_reg;        // Trace identifier
  logic       link_stb;                    // Rising link clock seen
  logic       take;                        // Byte accepted by framer

  // Framer state
  logic [3:0]       row_reg, row_next;
  logic [12:0]      col_reg, col_next;
  logic [3:0]       pos_row;               // Position of incoming byte
  logic [12:0]      pos_col;
  logic             seen_reg, seen_next;   // First frame start received
  logic [6:0]       scr_reg, scr_next;     // Scrambler stages one to seven
  logic [7:0]       acc_reg, acc_next;     // Parity of frame in progress
  logic [7:0]       bip_reg, bip_next;     // Parity of previous frame
  rts_pkg::rts_byte_t frm_reg, frm_next;   // Framed byte toward FIFO
  logic             fv_reg, fv_next;       // Framed byte valid
  logic             drop_reg, drop_next;   // Sticky overflow flag
  logic [7:0]       pre_byte;              // Byte before scrambling
  logic             in_soh;                // Unscrambled row-one overhead
  logic             at_seed;               // Scrambler reset point
  logic [14:0]      scr_res;               // Scrambler state and byte
  logic [7:0]       scr_byte;              // Byte as sent
  logic [6:0]       scr_after;             // Scrambler state after byte

  // FIFO hookup
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               pop;
  rts_pkg::rts_byte_t fifo_head;

  // Output pacing
  rts_pkg::rts_out_state_t st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        oclk_reg, oclk_next;
  logic [7:0]  odata_reg, odata_next;
  logic        ofs_reg, ofs_next;

  // Serial scrambler stepped eight times, MSB first
  function automatic logic [14:0] scramble_byte(input logic [6:0] st, input logic [7:0] d);
    logic [6:0] s;
    logic [7:0] o;
    s = st;
    o = d;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ s[6];
      s    = {s[5:0], s[6] ^ s[5]};
    end
    return {s, o};
  endfunction

  // Pin synchronisers; first stages feed only second stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_s1_reg <= rts_pkg::BYTE_RST;
      din_s2_reg <= rts_pkg::BYTE_RST;
      ck_s1_reg  <= 1'b0;
      ck_s2_reg  <= 1'b0;
      ck_s3_reg  <= 1'b0;
      fs_s1_reg  <= 1'b0;
      fs_s2_reg  <= 1'b0;
      ti_s1_reg  <= rts_pkg::BYTE_RST;
      ti_s2_reg  <= rts_pkg::BYTE_RST;
    end else if (en) begin
      din_s1_reg <= adapted_in_data;
      din_s2_reg <= din_s1_reg;
      ck_s1_reg  <= adapted_in_clock;
      ck_s2_reg  <= ck_s1_reg;
      ck_s3_reg  <= ck_s2_reg;
      fs_s1_reg  <= adapted_in_frame_start;
      fs_s2_reg  <= fs_s1_reg;
      ti_s1_reg  <= transmitted_trace_id;
      ti_s2_reg  <= ti_s1_reg;
    end
  end

  // Byte strobe on link clock rising edge
  assign link_stb = ck_s2_reg && !ck_s3_reg;
  assign take     = link_stb && (fs_s2_reg || seen_reg);

  // Position of the byte now arriving
  always_comb begin
    pos_row = row_reg;
    pos_col = col_reg + 13'h0001;
    if (fs_s2_reg) begin
      // Frame start marks row one, column one
      pos_row = rts_pkg::ROW_FIRST;
      pos_col = rts_pkg::COL_FIRST;
    end else if (col_reg == rts_pkg::COL_LAST) begin
      // Wrap to next row
      pos_col = rts_pkg::COL_FIRST;
      pos_row = (row_reg == rts_pkg::ROW_LAST) ? rts_pkg::ROW_FIRST : row_reg + 4'h1;
    end
  end

  // Overhead insertion and scrambling of one byte
  always_comb begin
    in_soh  = (pos_row == rts_pkg::ROW_FIRST) && (pos_col <= rts_pkg::SOH_LAST_COL);
    at_seed = (pos_row == rts_pkg::ROW_FIRST) && (pos_col == rts_pkg::SCR_START_COL);
    // Undefined channel and reserved bytes pass as received
    pre_byte = din_s2_reg;
    if (pos_row == rts_pkg::ROW_FIRST && pos_col <= rts_pkg::A1_LAST_COL) begin
      pre_byte = rts_pkg::FIRST_ALIGN_VALUE;
    end else if (pos_row == rts_pkg::ROW_FIRST && pos_col <= rts_pkg::A2_LAST_COL) begin
      pre_byte = rts_pkg::SECOND_ALIGN_VALUE;
    end else if (pos_row == rts_pkg::ROW_FIRST && pos_col == rts_pkg::TRACE_COL) begin
      pre_byte = ti_s2_reg;
    end else if (pos_row == rts_pkg::ROW_SECOND && pos_col == rts_pkg::PARITY_COL) begin
      pre_byte = bip_reg;
    end
    // Seed at reset point, then keep stepping
    scr_res   = scramble_byte(at_seed ? rts_pkg::SCR_SEED : scr_reg, pre_byte);
    scr_byte  = in_soh ? pre_byte : scr_res[7:0];
    scr_after = in_soh ? scr_reg : scr_res[14:8];
  end

  // Framer next state
  always_comb begin
    row_next  = row_reg;
    col_next  = col_reg;
    seen_next = seen_reg;
    scr_next  = scr_reg;
    acc_next  = acc_reg;
    bip_next  = bip_reg;
    frm_next  = frm_reg;
    fv_next   = fv_reg;
    drop_next = drop_reg;
    if (fv_reg && fifo_in_ready) begin
      // FIFO took the framed byte
      fv_next = 1'b0;
    end
    if (take) begin
      // Position advances on every byte, scrambler only outside row-one overhead
      row_next  = pos_row;
      col_next  = pos_col;
      seen_next = 1'b1;
      scr_next  = scr_after;
      if (fs_s2_reg) begin
        // Close previous frame parity, start new one
        bip_next = acc_reg;
        acc_next = scr_byte;
      end else begin
        acc_next = acc_reg ^ scr_byte;
      end
      if (fv_reg && !fifo_in_ready) begin
        // FIFO still full, byte lost
        drop_next = 1'b1;
      end else begin
        frm_next.data        = scr_byte;
        frm_next.frame_start = fs_s2_reg;
        fv_next              = 1'b1;
      end
    end
  end

  // Framer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_reg  <= rts_pkg::ROW_FIRST;
      col_reg  <= rts_pkg::COL_FIRST;
      seen_reg <= 1'b0;
      scr_reg  <= rts_pkg::SCR_SEED;
      acc_reg  <= rts_pkg::BYTE_RST;
      bip_reg  <= rts_pkg::BYTE_RST;
      frm_reg  <= '0;
      fv_reg   <= 1'b0;
      drop_reg <= 1'b0;
    end else if (en) begin
      row_reg  <= row_next;
      col_reg  <= col_next;
      seen_reg <= seen_next;
      scr_reg  <= scr_next;
      acc_reg  <= acc_next;
      bip_reg  <= bip_next;
      frm_reg  <= frm_next;
      fv_reg   <= fv_next;
      drop_reg <= drop_next;
    end
  end

  // Sixteen-byte storage plus head word between framer and output pacing
  rts_fifo #(
    .WIDTH (rts_pkg::WORD_W),
    .DEPTH (rts_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .en        (en),
    .in_valid  (fv_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (frm_reg),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_head)
  );

  // Output pacing: data changes on falling clock, stable at rising
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    oclk_next  = oclk_reg;
    odata_next = odata_reg;
    ofs_next   = ofs_reg;
    pop        = 1'b0;
    unique case (st_reg)
      rts_pkg::OUT_IDLE: begin
        // Wait for a byte, clock parked high
        if (fifo_out_valid) begin
          pop        = 1'b1;
          odata_next = fifo_head.data;
          ofs_next   = fifo_head.frame_start;
          oclk_next  = 1'b0;
          cnt_next   = rts_pkg::OUT_CNT_RST;
          st_next    = rts_pkg::OUT_LOW;
        end
      end
      rts_pkg::OUT_LOW: begin
        // Low half period
        if (cnt_reg == rts_pkg::OUT_HALF_LAST) begin
          oclk_next = 1'b1;
          cnt_next  = rts_pkg::OUT_CNT_RST;
          st_next   = rts_pkg::OUT_HIGH;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      rts_pkg::OUT_HIGH: begin
        // High half period, then next byte or idle
        if (cnt_reg != rts_pkg::OUT_HALF_LAST) begin
          cnt_next = cnt_reg + 4'h1;
        end else if (fifo_out_valid) begin
          pop        = 1'b1;
          odata_next = fifo_head.data;
          ofs_next   = fifo_head.frame_start;
          oclk_next  = 1'b0;
          cnt_next   = rts_pkg::OUT_CNT_RST;
          st_next    = rts_pkg::OUT_LOW;
        end else begin
          st_next = rts_pkg::OUT_IDLE;
        end
      end
      default: begin
        // Illegal one-hot code recovers to idle
        st_next = rts_pkg::OUT_IDLE;
      end
    endcase
  end

  // Output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg    <= rts_pkg::OUT_IDLE;
      cnt_reg   <= rts_pkg::OUT_CNT_RST;
      oclk_reg  <= 1'b1;
      odata_reg <= rts_pkg::BYTE_RST;
      ofs_reg   <= 1'b0;
    end else if (en) begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      oclk_reg  <= oclk_next;
      odata_reg <= odata_next;
      ofs_reg   <= ofs_next;
    end
  end

  assign section_out_data        = odata_reg;
  assign section_out_clock       = oclk_reg;
  assign section_out_frame_start = ofs_reg;
  assign byte_dropped            = drop_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_low_half;
    !section_out_clock [*4];
  endsequence
  sequence s_rise;
    section_out_clock;
  endsequence

  chk_out_clock_low: assert property ($fell(section_out_clock) |-> s_low_half ##1 s_rise)
    else $error("output clock low phase not four cycles");
  chk_first_align: assert property (take && pos_row == rts_pkg::ROW_FIRST
      && pos_col <= rts_pkg::A1_LAST_COL |-> scr_byte == rts_pkg::FIRST_ALIGN_VALUE)
    else $error("first alignment byte wrong");
  chk_second_align: assert property (take && pos_row == rts_pkg::ROW_FIRST
      && pos_col > rts_pkg::A1_LAST_COL && pos_col <= rts_pkg::A2_LAST_COL
      |-> scr_byte == rts_pkg::SECOND_ALIGN_VALUE)
    else $error("second alignment byte wrong");
  chk_trace_insert: assert property (take && pos_row == rts_pkg::ROW_FIRST
      && pos_col == rts_pkg::TRACE_COL |-> scr_byte == ti_s2_reg)
    else $error("trace byte not inserted");
  chk_parity_insert: assert property (take && pos_row == rts_pkg::ROW_SECOND
      && pos_col == rts_pkg::PARITY_COL |-> pre_byte == bip_reg)
    else $error("parity byte not inserted");
  chk_parity_close: assert property (take && fs_s2_reg |=> bip_reg == $past(acc_reg))
    else $error("parity not latched at frame start");
  chk_scr_seed: assert property (take && at_seed
      |-> scr_byte == (pre_byte ^ rts_pkg::SCR_FIRST_KEY))
    else $error("scrambler not seeded at reset point");
  chk_soh_clear: assert property (take && in_soh && !(fv_reg && !fifo_in_ready)
      |=> frm_reg.data == $past(pre_byte))
    else $error("row-one overhead was scrambled");
  chk_pos_track: assert property (take && fs_s2_reg
      |=> row_reg == rts_pkg::ROW_FIRST && col_reg == rts_pkg::COL_FIRST)
    else $error("position not reset by frame start");
  chk_fs_on_align: assert property (section_out_frame_start
      |-> section_out_data == rts_pkg::FIRST_ALIGN_VALUE)
    else $error("frame start not on first alignment byte");
endmodule // rts_trail_source

// ---- bench/rts_up_model.sv ----
// Upstream adaptation model: link clock, data byte and frame start source
`timescale 1ns/100ps
module rts_up_model (
  output logic [7:0] adapted_in_data,
  output logic       adapted_in_clock,
  output logic       adapted_in_frame_start
);
  // Idle link: clock parked low between frames
  initial begin
    adapted_in_data        = 8'h00;
    adapted_in_clock       = 1'b0;
    adapted_in_frame_start = 1'b0;
  end

  // One byte per link period, held half a period either side of the rise
  task automatic send_byte(input logic [7:0] d, input logic fs, input int half_ns);
    adapted_in_data        = d;
    adapted_in_frame_start = fs;
    #(half_ns);
    adapted_in_clock = 1'b1;
    #(half_ns);
    adapted_in_clock = 1'b0;  // Next byte or park follows in this time step
  endtask

  // Link released after a frame: stale byte no longer shown, marker dropped
  task automatic park();
    adapted_in_data        = ~adapted_in_data;
    adapted_in_frame_start = 1'b0;
  endtask
endmodule // rts_up_model

// ---- bench/rts_trail_source_bench.sv ----
// Self-checking bench for the section trail source
`timescale 1ns/100ps
module rts_trail_source_bench;
  logic       clk;         // System clock
  logic       nrst;        // Reset, active low
  logic       en;          // Clock enable
  logic [7:0] trace_id;    // Configured trace byte
  logic [7:0] in_data;     // Link byte
  logic       in_clock;    // Link clock
  logic       in_fs;       // Link frame start
  logic [7:0] out_data;    // Section byte
  logic       out_clock;   // Section byte clock
  logic       out_fs;      // Section frame start
  logic       dropped;     // Overflow flag
  logic [8:0] exp_q[$];    // Expected {frame start, byte}
  logic       chk_on;      // Monitor active
  int         n_fail;      // Mismatch count
  int         n_compared;  // Comparison count
  int         seed;        // Random seed
  logic [6:0] scr;         // Reference scrambler state
  logic [7:0] par_prev;    // Parity of previous frame
  logic [7:0] par_acc;     // Parity being gathered

  rts_trail_source i_dut (
    .clk                     (clk),
    .nrst                    (nrst),
    .en                      (en),
    .adapted_in_data         (in_data),
    .adapted_in_clock        (in_clock),
    .adapted_in_frame_start  (in_fs),
    .transmitted_trace_id    (trace_id),
    .section_out_data        (out_data),
    .section_out_clock       (out_clock),
    .section_out_frame_start (out_fs),
    .byte_dropped            (dropped)
  );

  rts_up_model i_up (
    .adapted_in_data        (in_data),
    .adapted_in_clock       (in_clock),
    .adapted_in_frame_start (in_fs)
  );

  // Free-running system clock
  always #(rts_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // Compare and count
  task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Next key byte, MSB first, x^7 + x^6 + 1
  function automatic logic [7:0] key_byte();
    logic [7:0] k;
    for (int i = 7; i >= 0; i--) begin
      k[i] = scr[6];                     // Seventh stage output
      scr  = {scr[5:0], scr[6] ^ scr[5]}; // Feedback taps
    end
    return k;
  endfunction

  // Send byte k of a frame and note its expected output
  task automatic send(input int k, input int half_ns);
    int         row;
    int         col;
    logic [7:0] d;
    logic [7:0] e;
    row = k / 4320;
    col = k % 4320 + 1;
    d   = 8'($random(seed));               // Random content avoids long runs
    e   = d;                               // Undefined bytes pass through
    if (row == 0 && col <= rts_pkg::A1_LAST_COL) e = rts_pkg::FIRST_ALIGN_VALUE;
    else if (row == 0 && col <= rts_pkg::A2_LAST_COL) e = rts_pkg::SECOND_ALIGN_VALUE;
    else if (row == 0 && col == rts_pkg::TRACE_COL) e = trace_id;
    else if (row == 1 && col == 1) e = par_prev;
    if (row == 0 && col == rts_pkg::SCR_START_COL) scr = rts_pkg::SCR_SEED;
    if (row > 0 || col > rts_pkg::SOH_LAST_COL) e = e ^ key_byte();
    par_acc = par_acc ^ e;                 // Even parity per bit position
    exp_q.push_back({k == 0, e});
    i_up.send_byte(d, k == 0, half_ns);
  endtask

  // Whole or cut-short frame; the next frame start closes it
  task automatic frame(input int n_bytes, input int half_ns);
    par_acc = 8'h00;
    for (int k = 0; k < n_bytes; k++) begin
      send(k, half_ns);
    end
    i_up.park();
    par_prev = par_acc;
  endtask

  // Output monitor, sampled at the rise where the byte is settled
  always @(posedge out_clock) begin
    if (chk_on) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[ERR] out byte expected none seen %h", {out_fs, out_data});
      end else begin
        check("out byte", {out_fs, out_data}, exp_q.pop_front());
      end
    end
  end

  // Hang guard
  initial begin
    #(90000 * rts_pkg::CLK_PERIOD_NS);
    n_fail++;
    wrap_up();
  end

  // Main sequence
  initial begin
    clk        = 1'b0;
    nrst       = 1'b0;
    en         = 1'b1;
    trace_id   = 8'h00;
    chk_on     = 1'b0;
    n_fail     = 0;
    n_compared = 0;
    seed       = 32'h9459;
    scr        = rts_pkg::SCR_SEED;
    par_prev   = 8'h00;
    par_acc    = 8'h00;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check("reset outputs", {out_fs, out_data}, 9'h000);
    check("reset flags", {7'h00, out_clock, dropped}, 9'h002);
    chk_on = 1'b1;
    // Two frames reaching row two: zero parity, then previous frame's parity
    repeat (2) begin
      @(posedge clk);
      trace_id <= 8'($random(seed));
      repeat (8) @(posedge clk);
      #37;
      frame(4322, rts_pkg::LINK_PERIOD_NS / 2);
    end
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) begin
      @(posedge clk);
    end
    check("bytes left", 9'(exp_q.size()), 9'h000);
    check("no drop", {8'h00, dropped}, 9'h000);
    // Burst faster than the output drains: FIFO fills, then empties
    chk_on = 1'b0;
    frame(120, 300);
    repeat (400) @(posedge clk);
    check("drop flag", {8'h00, dropped}, 9'h001);
    check("parked clock", {8'h00, out_clock}, 9'h001);
    wrap_up();
  end
endmodule // rts_trail_source_bench
